/* File: src/can_rx_fifo_acceptance_filter.sv */
// can receive path: acceptance filter, receive queue control, address map
// assumes a byte stream from the bit stream processor and a host port
// whose read and write strobes last one clock each
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// (RULE1) the receive window at 20..29 shows identifier, rtr and length.
// (RULE2) the queue holds 64 bytes, so the frame count varies with length.
// (RULE3) a frame that does not fit raises overrun and its bytes are dropped.
// (RULE4) overrun is flagged only when the frame stayed error-free to the end.
// (RULE5) only frames whose identifier passes the filter are stored.
// (RULE6) the filter code at address 4 is accessible only in reset mode.
// (RULE7) the filter mask at address 5 is accessible only in reset mode.
// (RULE8) an accepted frame is written descriptor first, then data bytes.
// (RULE9) a stored good frame sets receive full and, if enabled, the event.
// (RULE10) accept when every unmasked identifier bit equals its code bit.
// (RULE11) a mask bit of 0 compares its position and 1 ignores it.
// (RULE12) in extended mode the 80-byte internal ram maps from address 32.
// (RULE13) the extended map depends on mode; reset mode puts filters at 16..23.
// (RULE14) extended map, standard frame: info at 16, ids 17..18, data at 19.
// (RULE15) extended map, extended frame: info at 16, ids 17..20, data at 21.
// (RULE16) reset mode aborts the frame in flight; leaving it resumes.
// (RULE17) the host address msb is not decoded, so 128 up aliases 0 up.
module can_rx_fifo_acceptance_filter (
  input  wire logic                               core_clk_in,
  input  wire logic                               rst_in,
  input  wire logic [can_rx_pkg::HOST_ADDR_W-1:0] host_addr_in,
  input  wire logic                               host_wr_in,
  input  wire logic                               host_rd_in,
  input  wire logic [can_rx_pkg::BYTE_W-1:0]      host_wdata_in,
  output logic      [can_rx_pkg::BYTE_W-1:0]      host_rdata_out,
  input  wire logic                               rx_sof_in,
  input  wire logic                               rx_byte_valid_in,
  input  wire logic [can_rx_pkg::BYTE_W-1:0]      rx_byte_in,
  input  wire logic                               rx_frame_ok_in,
  input  wire logic                               rx_frame_err_in,
  output logic                                    receive_event_out,
  output logic                                    overrun_event_out,
  output logic                                    reset_mode_out
);
  import can_rx_pkg::*;

  typedef struct packed {
    rx_state_e                    st;
    logic [3:0]                   idx;
    logic [3:0]                   hdr;
    logic                         match;
    logic                         ovr_pend;
    logic                         reset_req;
    logic                         ext_mode;
    logic                         rx_en;
    logic                         ovr_en;
    logic                         ovr_flag;
    logic                         ovr_evt;
    logic [5:0]                   msg_count;
    logic [FILTER_BYTES-1:0][7:0] code;
    logic [FILTER_BYTES-1:0][7:0] mask;
    logic [SCRATCH_BYTES-1:0][7:0] scratch;
    logic [7:0]                   rdata;
  } top_state_s;

  top_state_s  s_r;
  top_state_s  s_nxt;
  rx_queue_if  q ();
  logic [6:0]  a7;
  logic        op_mode;
  logic [6:0]  win_off;
  logic [6:0]  filt_off;
  logic [6:0]  ram_off;
  logic [1:0]  cidx;
  logic        byte_ok;
  logic        m_now;
  logic [3:0]  hdr_now;
  logic        last_cmp;
  logic        reject_now;
  logic        overrun_now;
  logic        ovr_set;
  logic        ovr_clr;
  logic        release_cmd;
  logic [7:0]  rd_val;
  rx_queue u_queue (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .q           (q)
  );
  assign a7       = host_addr_in[6:0]; // RULE17
  assign op_mode  = !s_r.reset_req;
  assign win_off  = a7 - (s_r.ext_mode ? ADDR_EXT_WIN_FIRST
                                       : ADDR_STD_WIN_FIRST);
  assign filt_off = a7 - ADDR_EXT_WIN_FIRST;
  assign ram_off  = a7 - ADDR_RAM_FIRST;
  assign cidx     = 2'(s_r.idx - 4'h1);
  assign hdr_now  = (s_r.idx == 4'h0) ? hdr_len(s_r.ext_mode, rx_byte_in)
                                      : s_r.hdr;

  // filter compare of the byte now arriving
  always_comb begin
    byte_ok  = 1'b1;
    last_cmp = s_r.ext_mode ? (s_r.idx == hdr_now - 4'h1) : (s_r.idx == 4'h0);
    if (!s_r.ext_mode && s_r.idx == 4'h0) begin
      byte_ok = byte_pass(rx_byte_in, s_r.code[0], s_r.mask[0]); // RULE10
    end
    if (s_r.ext_mode && s_r.idx >= 4'h1 && s_r.idx <= 4'h4) begin
      byte_ok = byte_pass(rx_byte_in, s_r.code[cidx],
                          s_r.mask[cidx]); // RULE11
    end
  end
  assign m_now = s_r.match & byte_ok;
  always_comb begin
    s_nxt         = s_r;
    q.wr_en       = 1'b0;
    q.wr_data     = rx_byte_in;
    q.commit      = 1'b0;
    q.rollback    = 1'b0;
    q.peek_off    = win_off[3:0];
    q.ram_addr    = ram_off[5:0];
    q.ram_wr_en   = 1'b0;
    q.ram_wr_data = host_wdata_in;
    reject_now    = 1'b0;
    overrun_now   = 1'b0;
    ovr_set       = 1'b0;
    ovr_clr       = 1'b0;
    release_cmd   = 1'b0;
    s_nxt.ovr_evt = 1'b0;
    // receive side
    if (rx_sof_in) begin
      q.rollback     = (s_r.st == RX_STORE);
      s_nxt.st       = RX_STORE;
      s_nxt.idx      = 4'h0;
      s_nxt.match    = 1'b1;
      s_nxt.ovr_pend = 1'b0;
    end else begin
      unique case (s_r.st)
        RX_IDLE: begin
        end
        RX_STORE: begin
          if (rx_frame_err_in) begin
            q.rollback = 1'b1;
            s_nxt.st   = RX_IDLE;
          end else if (rx_frame_ok_in) begin
            q.commit   = s_r.match; // RULE9
            q.rollback = !s_r.match;
            s_nxt.st   = RX_IDLE;
          end else if (rx_byte_valid_in) begin
            if (last_cmp && !m_now) begin
              reject_now = 1'b1;
              q.rollback = 1'b1; // RULE5
              s_nxt.st   = RX_SKIP;
            end else if (q.used == QUEUE_FULL) begin
              // the whole partial frame goes, not just the tail
              overrun_now    = 1'b1;
              q.rollback     = 1'b1; // RULE3
              s_nxt.ovr_pend = 1'b1;
              s_nxt.st       = RX_SKIP;
            end else begin
              q.wr_en     = 1'b1; // RULE8
              s_nxt.idx   = s_r.idx + 4'h1;
              s_nxt.match = m_now;
              s_nxt.hdr   = hdr_now;
            end
          end
        end
        RX_SKIP: begin
          if (rx_frame_ok_in) begin
            ovr_set  = s_r.ovr_pend; // RULE4
            s_nxt.st = RX_IDLE;
          end else if (rx_frame_err_in) begin
            s_nxt.st = RX_IDLE;
          end
        end
        default: begin
          s_nxt.st = RX_IDLE;
        end
      endcase
    end
    // reset mode drops whatever frame is in flight
    if (s_r.reset_req) begin
      q.rollback     = (s_r.st == RX_STORE); // RULE16
      q.wr_en        = 1'b0;
      q.commit       = 1'b0;
      ovr_set        = 1'b0;
      reject_now     = 1'b0;
      overrun_now    = 1'b0;
      s_nxt.st       = RX_IDLE;
      s_nxt.ovr_pend = 1'b0;
    end
    // host writes
    if (host_wr_in) begin
      if (a7 == ADDR_MODE) begin
        s_nxt.reset_req = host_wdata_in[MODE_RESET_BIT];
        if (!s_r.ext_mode) begin
          s_nxt.rx_en  = host_wdata_in[CTRL_RX_EN_BIT];
          s_nxt.ovr_en = host_wdata_in[CTRL_OVR_EN_BIT];
        end
      end
      if (a7 == ADDR_CMD) begin
        release_cmd = host_wdata_in[CMD_RELEASE_BIT];
        ovr_clr     = host_wdata_in[CMD_CLR_OVR_BIT];
      end
      if (a7 == ADDR_CLKDIV && !op_mode) begin
        s_nxt.ext_mode = host_wdata_in[CLKDIV_EXT_BIT];
      end
      if (!s_r.ext_mode) begin
        if (!op_mode && a7 == ADDR_STD_CODE) begin
          s_nxt.code[0] = host_wdata_in; // RULE6
        end
        if (!op_mode && a7 == ADDR_STD_MASK) begin
          s_nxt.mask[0] = host_wdata_in; // RULE7
        end
      end else begin
        if (a7 == ADDR_EXT_IEN) begin
          s_nxt.rx_en  = host_wdata_in[IEN_RX_BIT];
          s_nxt.ovr_en = host_wdata_in[IEN_OVR_BIT];
        end
        if (!op_mode && a7 >= ADDR_EXT_WIN_FIRST
            && a7 <= ADDR_EXT_FILT_LAST) begin
          if (filt_off[2]) begin
            s_nxt.mask[filt_off[1:0]] = host_wdata_in; // RULE13
          end else begin
            s_nxt.code[filt_off[1:0]] = host_wdata_in; // RULE13
          end
        end
        if (!op_mode && a7 >= ADDR_RAM_FIRST && a7 <= ADDR_QUEUE_LAST) begin
          q.ram_wr_en = 1'b1; // RULE12
        end
        if (!op_mode && a7 > ADDR_QUEUE_LAST && a7 <= ADDR_RAM_LAST) begin
          s_nxt.scratch[ram_off[3:0]] = host_wdata_in; // RULE12
        end
      end
    end
    // release of the head frame, count kept in step with commits
    q.release_en  = release_cmd && (s_r.msg_count != 6'h00);
    q.release_len = frame_len(s_r.ext_mode, q.head0, q.head1);
    s_nxt.msg_count = s_r.msg_count + {5'h00, q.commit}
                      - {5'h00, q.release_en}; // RULE2
    // new overrun beats a clear in the same cycle
    s_nxt.ovr_flag = ovr_set | (s_r.ovr_flag & !ovr_clr); // RULE4
    s_nxt.ovr_evt  = ovr_set & !s_r.ovr_flag & s_r.ovr_en;
    // host reads
    rd_val = 8'h00;
    if (a7 == ADDR_STATUS) begin
      rd_val = {6'h00, s_r.ovr_flag, (s_r.msg_count != 6'h00)};
    end else if (a7 == ADDR_CLKDIV) begin
      rd_val = {s_r.ext_mode, 7'h00};
    end else if (!s_r.ext_mode) begin
      if (a7 == ADDR_MODE) begin
        rd_val = {4'h0, s_r.ovr_en, 1'b0, s_r.rx_en, s_r.reset_req};
      end else if (a7 == ADDR_STD_CODE) begin
        rd_val = op_mode ? LOCKED_READ : s_r.code[0]; // RULE6
      end else if (a7 == ADDR_STD_MASK) begin
        rd_val = op_mode ? LOCKED_READ : s_r.mask[0]; // RULE7
      end else if (a7 >= ADDR_STD_WIN_FIRST && a7 <= ADDR_STD_WIN_LAST) begin
        rd_val = q.peek_data; // RULE1
      end
    end else begin
      if (a7 == ADDR_MODE) begin
        rd_val = {7'h00, s_r.reset_req};
      end else if (a7 == ADDR_EXT_IEN) begin
        rd_val = {4'h0, s_r.ovr_en, 2'h0, s_r.rx_en};
      end else if (a7 >= ADDR_EXT_WIN_FIRST && a7 <= ADDR_EXT_WIN_LAST) begin
        if (op_mode) begin
          rd_val = q.peek_data; // RULE14 RULE15
        end else if (a7 <= ADDR_EXT_FILT_LAST) begin
          rd_val = filt_off[2] ? s_r.mask[filt_off[1:0]]
                               : s_r.code[filt_off[1:0]]; // RULE13
        end
      end else if (a7 == ADDR_MSG_COUNT) begin
        rd_val = {2'h0, s_r.msg_count};
      end else if (a7 == ADDR_RX_START) begin
        rd_val = {2'h0, q.rd_base};
      end else if (a7 >= ADDR_RAM_FIRST && a7 <= ADDR_QUEUE_LAST) begin
        rd_val = q.ram_rd_data; // RULE12
      end else if (a7 > ADDR_QUEUE_LAST && a7 <= ADDR_RAM_LAST) begin
        rd_val = s_r.scratch[ram_off[3:0]];
      end
    end
    if (host_rd_in) begin
      s_nxt.rdata = rd_val;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r           <= '0;
      s_r.st        <= RX_IDLE;
      s_r.reset_req <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign host_rdata_out    = s_r.rdata;
  assign receive_event_out = s_r.rx_en & (s_r.msg_count != 6'h00); // RULE9
  assign overrun_event_out = s_r.ovr_evt;
  assign reset_mode_out    = s_r.reset_req;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_win_head: assert property ( // RULE1
    host_rd_in && !s_r.ext_mode && a7 == ADDR_STD_WIN_FIRST
    |=> host_rdata_out == $past(q.head0))
    else $error("receive window first byte is not the queue head");
  a_queue_bound: assert property (q.used <= QUEUE_FULL) // RULE2
    else $error("receive queue holds more than its capacity");
  a_overrun_drop: assert property ( // RULE3
    overrun_now |-> q.rollback && !q.wr_en ##1 s_r.st == RX_SKIP)
    else $error("overrun did not discard the partial frame");
  a_overrun_flag: assert property ( // RULE4
    $rose(s_r.ovr_flag) |-> $past(rx_frame_ok_in) && $past(s_r.ovr_pend))
    else $error("overrun flagged without a good frame end");
  a_reject_drop: assert property ( // RULE5
    reject_now && !q.release_en |=> s_r.st == RX_SKIP
    && q.used == $past(q.used) - {3'h0, $past(s_r.idx)})
    else $error("rejected frame left bytes in the queue");
  a_code_lock: assert property ( // RULE6
    host_wr_in && op_mode && a7 == ADDR_STD_CODE |=> $stable(s_r.code))
    else $error("filter code changed outside reset mode");
  a_mask_lock: assert property ( // RULE7
    host_wr_in && op_mode && a7 == ADDR_STD_MASK |=> $stable(s_r.mask))
    else $error("filter mask changed outside reset mode");
  a_seq_write: assert property ( // RULE8
    q.wr_en && !q.rollback && !q.release_en
    |=> q.used == $past(q.used) + 7'h01)
    else $error("stored byte did not advance the queue");
  a_full_set: assert property ( // RULE9
    q.commit && !q.release_en |=> s_r.msg_count == $past(s_r.msg_count) + 6'h01
    && s_r.msg_count != 6'h00)
    else $error("stored frame did not set receive full");
  a_mask_open: assert property ( // RULE10
    s_r.st == RX_STORE && rx_byte_valid_in && !rx_sof_in && !s_r.ext_mode
    && s_r.idx == 4'h0 && s_r.mask[0] == 8'hFF |-> !reject_now)
    else $error("all-ones mask rejected a frame");
  a_mask_cmp: assert property ( // RULE11
    s_r.st == RX_STORE && rx_byte_valid_in && !rx_sof_in && !s_r.reset_req
    && !rx_frame_ok_in && !rx_frame_err_in && !s_r.ext_mode
    && s_r.idx == 4'h0
    && ((rx_byte_in ^ s_r.code[0]) & ~s_r.mask[0]) != 8'h00 |-> reject_now)
    else $error("compared identifier mismatch was accepted");
  a_ram_map: assert property ( // RULE12
    host_rd_in && s_r.ext_mode && a7 == ADDR_RAM_FIRST
    |=> host_rdata_out == $past(q.ram_rd_data))
    else $error("internal ram not seen at its base address");
  a_reset_map: assert property ( // RULE13
    host_rd_in && s_r.ext_mode && !op_mode && a7 == ADDR_STD_WIN_FIRST
    |=> host_rdata_out == $past(s_r.mask[0]))
    else $error("first filter mask byte not at its reset-mode address");
  a_info_map: assert property ( // RULE14
    host_rd_in && s_r.ext_mode && op_mode && a7 == ADDR_EXT_WIN_FIRST
    |=> host_rdata_out == $past(q.head0))
    else $error("frame information not at the window start");
  a_data_eff: assert property ( // RULE15
    host_rd_in && s_r.ext_mode && op_mode && a7 == ADDR_EXT_DATA1_EFF
    |=> host_rdata_out == $past(q.peek_data) && $past(q.peek_off) == 4'h5)
    else $error("extended frame data byte 1 misplaced");
  a_reset_abort: assert property ( // RULE16
    s_r.reset_req |=> s_r.st == RX_IDLE && !s_r.ovr_pend)
    else $error("reset mode did not abort reception");

  c_frame_stored: cover property (s_r.st == RX_STORE && q.commit);
  c_overrun: cover property ($rose(s_r.ovr_flag));
  c_rejected: cover property (reject_now);
  c_released: cover property (q.release_en ##1 s_r.msg_count != 6'h00);
endmodule // can_rx_fifo_acceptance_filter
`default_nettype wire

/* File: src/can_rx_pkg.sv */
// constants, types and helpers for the can receive path and address decoder
// assumes an 8-bit host register port and a byte-wide frame stream
package can_rx_pkg;
  localparam int BYTE_W        = 8;
  localparam int HOST_ADDR_W   = 8;
  localparam int QUEUE_BYTES   = 64;
  localparam int SCRATCH_BYTES = 16;
  localparam int FILTER_BYTES  = 4;
  localparam logic [6:0] QUEUE_FULL = 7'h40;

  // register offsets, seven decoded address bits
  localparam logic [6:0] ADDR_MODE          = 7'h00;
  localparam logic [6:0] ADDR_CMD           = 7'h01;
  localparam logic [6:0] ADDR_STATUS        = 7'h02;
  localparam logic [6:0] ADDR_STD_CODE      = 7'h04;
  localparam logic [6:0] ADDR_STD_MASK      = 7'h05;
  localparam logic [6:0] ADDR_EXT_IEN       = 7'h04;
  localparam logic [6:0] ADDR_EXT_WIN_FIRST = 7'h10;
  localparam logic [6:0] ADDR_EXT_FILT_LAST = 7'h17;
  localparam logic [6:0] ADDR_EXT_WIN_LAST  = 7'h1C;
  localparam logic [6:0] ADDR_EXT_DATA1_EFF = 7'h15;
  localparam logic [6:0] ADDR_STD_WIN_FIRST = 7'h14;
  localparam logic [6:0] ADDR_STD_WIN_LAST  = 7'h1D;
  localparam logic [6:0] ADDR_MSG_COUNT     = 7'h1D;
  localparam logic [6:0] ADDR_RX_START      = 7'h1E;
  localparam logic [6:0] ADDR_CLKDIV        = 7'h1F;
  localparam logic [6:0] ADDR_RAM_FIRST     = 7'h20;
  localparam logic [6:0] ADDR_QUEUE_LAST    = 7'h5F;
  localparam logic [6:0] ADDR_RAM_LAST      = 7'h6F;

  // field positions
  localparam int MODE_RESET_BIT  = 0;
  localparam int CTRL_RX_EN_BIT  = 1;
  localparam int CTRL_OVR_EN_BIT = 3;
  localparam int IEN_RX_BIT      = 0;
  localparam int IEN_OVR_BIT     = 3;
  localparam int CMD_RELEASE_BIT = 2;
  localparam int CMD_CLR_OVR_BIT = 3;
  localparam int CLKDIV_EXT_BIT  = 7;

  localparam logic [7:0] LOCKED_READ  = 8'hFF;
  localparam logic [3:0] STD_HDR_LEN  = 4'h2;
  localparam logic [3:0] EXT_HDR_SFF  = 4'h3;
  localparam logic [3:0] EXT_HDR_EFF  = 4'h5;
  localparam logic [3:0] MAX_DATA     = 4'h8;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_STORE = 3'b010,
    RX_SKIP  = 3'b100
  } rx_state_e;

  function automatic logic [3:0] data_count(input logic rtr,
                                            input logic [3:0] dlc);
    if (rtr) return 4'h0;
    if (dlc > MAX_DATA) return MAX_DATA;
    return dlc;
  endfunction

  function automatic logic [3:0] hdr_len(input logic ext,
                                         input logic [7:0] b0);
    if (!ext) return STD_HDR_LEN;
    return b0[7] ? EXT_HDR_EFF : EXT_HDR_SFF;
  endfunction

  function automatic logic [3:0] frame_len(input logic ext,
                                           input logic [7:0] b0,
                                           input logic [7:0] b1);
    if (!ext) return STD_HDR_LEN + data_count(b1[4], b1[3:0]);
    return hdr_len(ext, b0) + data_count(b0[6], b0[3:0]);
  endfunction

  function automatic logic byte_pass(input logic [7:0] id,
                                     input logic [7:0] code,
                                     input logic [7:0] mask);
    return &(~(id ^ code) | mask);
  endfunction
endpackage

/* File: src/rx_queue.sv */
// circular 64-byte receive queue with speculative write and commit
// assumes the controller never writes past a full queue
`timescale 1ns/1ns
`default_nettype none
module rx_queue (
  input wire logic   core_clk_in,
  input wire logic   rst_in,
  rx_queue_if.store  q
);
  import can_rx_pkg::*;

  typedef struct packed {
    logic [QUEUE_BYTES-1:0][7:0] mem;
    logic [6:0]                  wr;
    logic [6:0]                  commit;
    logic [6:0]                  rd;
  } queue_state_s;

  queue_state_s s_r;
  queue_state_s s_nxt;
  logic [5:0]   peek_idx;
  logic [5:0]   head1_idx;

  always_comb begin
    s_nxt = s_r;
    if (q.wr_en) begin
      s_nxt.mem[s_r.wr[5:0]] = q.wr_data;
      s_nxt.wr = s_r.wr + 7'h01;
    end else if (q.ram_wr_en) begin
      s_nxt.mem[q.ram_addr] = q.ram_wr_data;
    end
    // a dropped frame gives back every byte it took
    if (q.rollback) begin
      s_nxt.wr = s_r.commit;
    end
    if (q.commit) begin
      s_nxt.commit = s_r.wr;
    end
    if (q.release_en) begin
      s_nxt.rd = s_r.rd + {3'h0, q.release_len};
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign peek_idx      = s_r.rd[5:0] + {2'h0, q.peek_off};
  assign head1_idx     = s_r.rd[5:0] + 6'h01;
  assign q.peek_data   = s_r.mem[peek_idx];
  assign q.head0       = s_r.mem[s_r.rd[5:0]];
  assign q.head1       = s_r.mem[head1_idx];
  assign q.ram_rd_data = s_r.mem[q.ram_addr];
  assign q.used        = s_r.wr - s_r.rd;
  assign q.rd_base     = s_r.rd[5:0];
endmodule // rx_queue
`default_nettype wire

/* File: src/rx_queue_if.sv */
// signals between the receive controller and the receive queue storage
// assumes both ends share one clock
`timescale 1ns/1ns
`default_nettype none
interface rx_queue_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       commit;
  logic       rollback;
  logic       release_en;
  logic [3:0] release_len;
  logic [3:0] peek_off;
  logic [7:0] peek_data;
  logic [7:0] head0;
  logic [7:0] head1;
  logic [5:0] ram_addr;
  logic       ram_wr_en;
  logic [7:0] ram_wr_data;
  logic [7:0] ram_rd_data;
  logic [6:0] used;
  logic [5:0] rd_base;
  modport ctrl (output wr_en, wr_data, commit, rollback, release_en,
                release_len, peek_off, ram_addr, ram_wr_en, ram_wr_data,
                input peek_data, head0, head1, ram_rd_data, used, rd_base);
  modport store (input wr_en, wr_data, commit, rollback, release_en,
                 release_len, peek_off, ram_addr, ram_wr_en, ram_wr_data,
                 output peek_data, head0, head1, ram_rd_data, used,
                 rd_base);
endinterface
`default_nettype wire

/* File: tb/can_rx_fifo_acceptance_filter_test.sv */
// register-call tests of the receive path, filter and address map
// assumes frame_src as the byte-stream source; standard and extended maps
`timescale 1ns/1ns
`default_nettype none
module can_rx_fifo_acceptance_filter_test;
  import can_rx_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       hi = 1'b0;
  logic [7:0] addr = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       sof, vld, ok, err, ev, ovr_ev, rmode;
  logic [7:0] rx_b;
  int         err_total = 0;
  int         n_compared = 0;
  int         ovr_n = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (ovr_ev === 1'b1) ovr_n++;
  frame_src src (.clk_in(clk), .sof_out(sof), .vld_out(vld),
                 .byte_out(rx_b), .ok_out(ok), .err_out(err));
  can_rx_fifo_acceptance_filter DUT (.core_clk_in(clk), .rst_in(rst),
    .host_addr_in(addr), .host_wr_in(wr_s), .host_rd_in(rd_s),
    .host_wdata_in(wdata), .host_rdata_out(rdata), .rx_sof_in(sof),
    .rx_byte_valid_in(vld), .rx_byte_in(rx_b), .rx_frame_ok_in(ok),
    .rx_frame_err_in(err), .receive_event_out(ev),
    .overrun_event_out(ovr_ev), .reset_mode_out(rmode));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) #1 wr_s = 1'b1;
    addr = {hi, a};
    wdata = d;
    @(posedge clk) #1 wr_s = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk) #1 rd_s = 1'b1;
    addr = {hi, a};
    @(posedge clk) #1 rd_s = 1'b0;
    chk(rdata, e);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk({7'h0, rmode}, 8'h01);
    wr(ADDR_STD_CODE, 8'hA5);
    wr(ADDR_STD_MASK, 8'h0F);
    rd(ADDR_STD_CODE, 8'hA5);
    rd(ADDR_STD_MASK, 8'h0F);
    wr(ADDR_MODE, 8'h0A);
    rd(ADDR_STD_CODE, LOCKED_READ);
    // a mask write that slipped through would let the next frame pass
    wr(ADDR_STD_MASK, 8'hFF);
    src.send(8'hB5, 8'h02, 2, 1'b1);
    hi = 1'b1;
    rd(ADDR_STATUS, 8'h00);
    hi = 1'b0;
    src.send(8'hAC, 8'h02, 2, 1'b1);
    rd(ADDR_STATUS, 8'h01);
    chk({7'h0, ev}, 8'h01);
    rd(7'h14, 8'hAC);
    rd(7'h15, 8'h02);
    rd(7'h16, 8'h01);
    rd(7'h17, 8'h02);
    wr(ADDR_CMD, 8'h04);
    rd(ADDR_STATUS, 8'h00);
    chk({7'h0, ev}, 8'h00);
    $display("filter test done");
    for (int i = 0; i < 6; i++) src.send(8'hA0, 8'h08, 8, 1'b1);
    src.send(8'hA0, 8'h08, 8, 1'b0);
    rd(ADDR_STATUS, 8'h01);
    chk(8'(ovr_n), 8'h00);
    src.send(8'hA0, 8'h08, 8, 1'b1);
    rd(ADDR_STATUS, 8'h03);
    chk(8'(ovr_n), 8'h01);
    for (int i = 0; i < 6; i++) begin
      rd(7'h1D, 8'h08);
      wr(ADDR_CMD, 8'h04);
    end
    rd(ADDR_STATUS, 8'h02);
    wr(ADDR_CMD, 8'h08);
    rd(ADDR_STATUS, 8'h00);
    $display("overrun test done");
    wr(ADDR_MODE, 8'h0B);
    wr(ADDR_STD_MASK, 8'hFF);
    src.send(8'hAC, 8'h02, 2, 1'b1);
    wr(ADDR_MODE, 8'h0A);
    rd(ADDR_STATUS, 8'h00);
    chk({7'h0, rmode}, 8'h00);
    // all-ones mask must take identifier 00, which differs from code A5 in four bits
    src.send(8'h00, 8'h00, 0, 1'b1);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_CMD, 8'h04);
    $display("reset mode test done");
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CLKDIV, 8'h80);
    wr(7'h10, 8'hA5);
    wr(7'h14, 8'h0F);
    for (int i = 21; i < 24; i++) wr(7'(i), 8'hFF);
    wr(ADDR_EXT_IEN, 8'h01);
    wr(ADDR_RAM_FIRST, 8'h3C);
    wr(7'h60, 8'hC3);
    rd(7'h10, 8'hA5);
    rd(7'h14, 8'h0F);
    rd(ADDR_RAM_FIRST, 8'h3C);
    rd(7'h60, 8'hC3);
    rd(ADDR_CLKDIV, 8'h80);
    wr(ADDR_MODE, 8'h00);
    src.send(8'h82, 8'hA5, 5, 1'b1);
    rd(7'h10, 8'h82);
    rd(7'h11, 8'hA5);
    rd(7'h15, 8'h04);
    rd(ADDR_MSG_COUNT, 8'h01);
    rd(ADDR_RX_START, 8'h02);
    chk({7'h0, ev}, 8'h01);
    wr(ADDR_CMD, 8'h04);
    rd(ADDR_RX_START, 8'h09);
    // a code write slipping through in operating mode would reject this
    wr(7'h10, 8'h00);
    src.send(8'h01, 8'hA5, 2, 1'b1);
    rd(7'h13, 8'h02);
    rd(ADDR_STATUS, 8'h01);
    $display("extended map test done");
    print_verdict();
  end
endmodule // can_rx_fifo_acceptance_filter_test
`default_nettype wire

/* File: tb/frame_src.sv */
// byte-stream frame source in place of the bit stream processor
// assumes the sink samples every strobe on the rising edge of clk_in
`timescale 1ns/1ns
`default_nettype none
module frame_src (
  input  wire logic       clk_in,
  output logic            sof_out,
  output logic            vld_out,
  output logic [7:0]      byte_out,
  output logic            ok_out,
  output logic            err_out
);
  initial begin
    {sof_out, vld_out, ok_out, err_out} = 4'h0;
    byte_out = 8'h00;
  end
  // data bytes count up from 1; idle byte lines show the inverse
  task automatic send(input logic [7:0] b0, input logic [7:0] b1,
                      input int nd, input logic good);
    logic [7:0] b;
    b = 8'h00;
    @(posedge clk_in) #1 sof_out = 1'b1;
    for (int i = 0; i < nd + 2; i++) begin
      b = (i == 0) ? b0 : (i == 1) ? b1 : 8'(i - 1);
      @(posedge clk_in) #1 sof_out = 1'b0;
      vld_out = 1'b1;
      byte_out = b;
    end
    @(posedge clk_in) #1 vld_out = 1'b0;
    byte_out = ~b;
    ok_out = good;
    err_out = !good;
    @(posedge clk_in) #1 ok_out = 1'b0;
    err_out = 1'b0;
  endtask
endmodule // frame_src
`default_nettype wire
